// *** src/spcg_pkg.sv ***
package spcg_pkg;
  // packet layout
  localparam int PKT_W = 32;
  localparam int ID_W = 8;
  localparam int DAT_W = 24;
  localparam int BIT_CNT_W = 6;
  localparam logic [5:0] PKT_BITS = 6'h20;
  localparam int FIFO_DEPTH = 32;

  // incoming packet ids
  localparam logic [7:0] ID_CHECKSUM = 8'h00;
  localparam logic [7:0] ID_CONFIG = 8'h01;
  localparam logic [7:0] ID_CONTROL = 8'h02;
  localparam logic [7:0] ID_ALLFRAME = 8'h03;
  localparam logic [7:0] ID_RXLINE = 8'h0f;
  localparam logic [7:0] ID_RXOFF = 8'h10;
  localparam logic [7:0] ID_WARM_LO = 8'h11;
  localparam logic [7:0] ID_WARM_HI = 8'h15;
  localparam logic [7:0] ID_SYNC3200 = 8'h16;
  localparam logic [7:0] ID_SYNC1600 = 8'h17;
  localparam logic [7:0] ID_DATA3200 = 8'h18;
  localparam logic [7:0] ID_DATA1600 = 8'h19;
  localparam logic [7:0] ID_SHUT1 = 8'h1a;
  localparam logic [7:0] ID_SHUT2 = 8'h1b;
  localparam logic [7:0] ID_SPEC_LO = 8'h1c;
  localparam logic [7:0] ID_SPEC_HI = 8'h1f;
  localparam logic [7:0] ID_FRAME_LO = 8'h20;
  localparam logic [7:0] ID_FRAME_HI = 8'h27;
  localparam logic [7:0] ID_ADDR_EN = 8'h78;
  localparam logic [7:0] ID_SLOT_LO = 8'h80;
  localparam logic [7:0] ID_SLOT_HI = 8'h8f;

  // outgoing packet ids
  localparam logic [7:0] OID_BIW = 8'h00;
  localparam logic [7:0] OID_ADDR = 8'h01;
  localparam logic [7:0] OID_MSG_LO = 8'h02;
  localparam logic [7:0] OID_MSG_HI = 8'h57;
  localparam logic [7:0] OID_STATUS = 8'h7f;
  localparam logic [7:0] OID_PART = 8'hff;

  // identity data, value arbitrary
  localparam logic [23:0] PART_DATA = 24'h00a5c3;

  // start-up delay: 1 s at 50 MHz system clock
  localparam longint STARTUP_NS = 64'd1000000000;
  localparam longint CLK_NS = 64'd20;
  localparam longint STARTUP_CYC = STARTUP_NS / CLK_NS;

  // packet classes
  typedef enum logic [3:0] {
    SPCG_C_NONE = 4'h0, SPCG_C_CSUM = 4'h1, SPCG_C_CFG = 4'h2,
    SPCG_C_CTRL = 4'h3, SPCG_C_ALLF = 4'h4, SPCG_C_RXLINE = 4'h5,
    SPCG_C_RXSET = 4'h6, SPCG_C_FRAME = 4'h7, SPCG_C_ADDREN = 4'h8,
    SPCG_C_SLOT = 4'h9, SPCG_C_SPECIAL = 4'ha
  } spcg_class_t;

  // decoded command toward the decoder core
  typedef struct packed {
    spcg_class_t cls;
    logic [3:0] index;   // stage, frame group or slot
    logic [23:0] data;
  } spcg_cmd_t;

  // outgoing packet
  typedef struct packed {
    logic [7:0] id;
    logic [23:0] data;
  } spcg_pkt_t;

  // link states, gray along idle-shift-done-wait
  typedef enum logic [1:0] {
    SPCG_IDLE = 2'b00, SPCG_SHIFT = 2'b01,
    SPCG_DONE = 2'b11, SPCG_HOLD = 2'b10
  } spcg_state_t;
endpackage

// *** src/spcg_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module spcg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
  // pointers
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** src/spcg_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - ids 00-03 checksum, config, control, allframe
// - ids 0F-15 receiver line, off, warm-up
// - ids 16-1B sync, data, shut-down settings
// - ids 20-27 frame groups, descending
// - id 78 enable, 80-8F address slots
// - outgoing ids biw, address, message, status, part
// - xor data except checksum and special
// - checksum reset to part identity data
// - reset or non-checksum packet closes gate
// - closed gate sends part identity each packet
// - matching checksum packet opens gate
// - open gate ignores checksum packets
// - open gate with data requests transfer
// - open gate with empty buffer sends status packet
// - ready asserted about 1 s after reset
// - ready inactive at packet end, then active if selected or device requests
// - sync entry requests status transfer
// - 32-bit packets, msb first, rising edge
// - ready released after 32 bits clocked
// - 32-entry buffer, overflow stops and clears
// - wait 50000000 cycles before first ready
module spcg_gate #(
  parameter longint STARTUP_CYCLES = spcg_pkg::STARTUP_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link pins
  input wire logic sel_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic ready_n_o,
  // decoded commands toward decoder core
  output spcg_pkg::spcg_cmd_t cmd_o,
  output logic cmd_valid_o,
  // outgoing data from decoder core
  input wire spcg_pkg::spcg_pkt_t data_i,
  input wire logic data_valid_i,
  output logic data_ready_o,
  input wire logic sync_entered_i,
  // state
  output logic tx_enable_o,
  output logic overflow_o
);
  import spcg_pkg::*;

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [1:0] sck_s;
  logic [1:0] sel_s;
  logic [1:0] mosi_s;
  logic sck_d;
  // two stages per pin, edges found on the second stage only
  always_ff @(posedge clk_i) begin
    sck_s <= {sck_s[0], sck_i};
    sel_s <= {sel_s[0], sel_n_i};
    mosi_s <= {mosi_s[0], mosi_i};
    sck_d <= sck_s[1];
  end
  wire sck_rise = sck_s[1] && !sck_d;
  wire sck_fall = !sck_s[1] && sck_d;
  wire selected = !sel_s[1];

  // ----------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------
  spcg_state_t state;
  spcg_state_t next_state;
  logic [PKT_W-1:0] rx_sr;
  logic [PKT_W-1:0] tx_sr;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [DAT_W-1:0] csum;
  logic tx_en;
  logic started;
  logic [31:0] boot_cnt;
  logic sync_pend;
  logic ready_n;
  logic from_fifo;

  // fifo between decoder core and link
  logic fifo_out_valid;
  logic fifo_pop;
  logic fifo_in_ready;
  logic [PKT_W-1:0] fifo_out_data;

  // ----------------------------------------------------------
  // incoming packet decode
  // ----------------------------------------------------------
  wire [ID_W-1:0] rx_id = rx_sr[PKT_W-1:DAT_W];
  wire [DAT_W-1:0] rx_dat = rx_sr[DAT_W-1:0];
  wire pkt_end = (state == SPCG_DONE);
  wire is_csum = (rx_id == ID_CHECKSUM);
  wire is_cfg = (rx_id == ID_CONFIG);
  wire is_ctrl = (rx_id == ID_CONTROL);
  wire is_allf = (rx_id == ID_ALLFRAME);
  wire is_rxline = (rx_id == ID_RXLINE);
  wire is_rxoff = (rx_id == ID_RXOFF);
  wire is_warm = (rx_id >= ID_WARM_LO) && (rx_id <= ID_WARM_HI);
  wire is_rxrate = (rx_id >= ID_SYNC3200) && (rx_id <= ID_DATA1600);
  wire is_shut = (rx_id == ID_SHUT1) || (rx_id == ID_SHUT2);
  wire is_rxset = is_rxoff || is_warm || is_rxrate || is_shut;
  // frame groups, id 20 is the top group
  wire is_frame = (rx_id >= ID_FRAME_LO) && (rx_id <= ID_FRAME_HI);
  wire [3:0] frame_grp = 4'(ID_FRAME_HI - rx_id);
  wire is_addren = (rx_id == ID_ADDR_EN);
  wire is_slot = (rx_id >= ID_SLOT_LO) && (rx_id <= ID_SLOT_HI);
  // special packets stay out of the checksum
  wire is_spec = (rx_id >= ID_SPEC_LO) && (rx_id <= ID_SPEC_HI);
  wire [3:0] rx_index = is_frame ? frame_grp :
                        is_rxset ? 4'(rx_id - ID_RXOFF) : rx_id[3:0];
  spcg_class_t rx_cls;
  always_comb begin
    rx_cls = SPCG_C_NONE;
    if (is_csum) rx_cls = SPCG_C_CSUM;
    else if (is_cfg) rx_cls = SPCG_C_CFG;
    else if (is_ctrl) rx_cls = SPCG_C_CTRL;
    else if (is_allf) rx_cls = SPCG_C_ALLF;
    else if (is_rxline) rx_cls = SPCG_C_RXLINE;
    else if (is_rxset) rx_cls = SPCG_C_RXSET;
    else if (is_frame) rx_cls = SPCG_C_FRAME;
    else if (is_addren) rx_cls = SPCG_C_ADDREN;
    else if (is_slot) rx_cls = SPCG_C_SLOT;
    else if (is_spec) rx_cls = SPCG_C_SPECIAL;
  end
  // reserved ids from the host decode as no command

  // ----------------------------------------------------------
  // outgoing packet select
  // ----------------------------------------------------------
  wire [PKT_W-1:0] part_pkt = {OID_PART, PART_DATA};
  // status built on demand, carries gate and sync state
  wire [PKT_W-1:0] stat_pkt = {OID_STATUS, 21'h0, overflow_o, sync_pend,
                               tx_en};
  // outgoing ids come with the packet or from constants
  // closed gate always sends part identity
  wire [PKT_W-1:0] tx_load = !tx_en ? part_pkt :
                             fifo_out_valid ? fifo_out_data : stat_pkt;
  wire load_fifo = tx_en && fifo_out_valid;

  // ----------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------
  wire boot_done = (boot_cnt >= 32'(STARTUP_CYCLES));
  // a frame opens on its first link clock rise, not on select alone:
  // select still reads low for a few cycles after the host lets go,
  // and a frame must not open on that stale level
  wire first_rise = (state == SPCG_IDLE) && selected && started && sck_rise;
  // bits move in on rises of an open frame, out on its falls only;
  // the last fall of a frame lands in idle and is dropped there
  wire shift_in = sck_rise && ((state == SPCG_SHIFT) || first_rise);
  wire shift_out = sck_fall && (state == SPCG_SHIFT);
  // idle keeps the outgoing word fresh until the frame opens
  wire tx_reload = (state == SPCG_IDLE) && !first_rise;
  // shift full packet on rising edges
  always_comb begin
    next_state = state;
    unique case (state)
      SPCG_IDLE: if (first_rise) next_state = SPCG_SHIFT;
      SPCG_SHIFT: if (sck_rise && bit_cnt == PKT_BITS - 6'h1)
        next_state = SPCG_DONE;
      SPCG_DONE: next_state = SPCG_HOLD;
      SPCG_HOLD: next_state = SPCG_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) state <= SPCG_IDLE;
    else state <= next_state;
  end

  // shift registers and bit count
  always_ff @(posedge clk_i) begin
    if (rst_i || tx_reload) begin
      bit_cnt <= '0;
      rx_sr <= '0;
      tx_sr <= tx_load;
      from_fifo <= load_fifo;
    end else if (shift_in) begin
      bit_cnt <= bit_cnt + 6'h1;
      rx_sr <= {rx_sr[PKT_W-2:0], mosi_s[1]};
    end else if (shift_out) begin
      tx_sr <= {tx_sr[PKT_W-2:0], 1'b0};
    end
  end
  // buffered packet leaves the fifo once sent
  assign fifo_pop = pkt_end && from_fifo;

  // ----------------------------------------------------------
  // checksum gate
  // ----------------------------------------------------------
  // gate and sum move only at packet end; a checksum packet never
  // folds into the sum, whatever the gate state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csum <= PART_DATA;
      tx_en <= 1'b0;
    end else if (pkt_end) begin
      if (is_csum) begin
        if (!tx_en && rx_dat == csum) tx_en <= 1'b1;
      end else begin
        // any other packet closes the gate
        tx_en <= 1'b0;
        if (!is_spec) csum <= csum ^ rx_dat;
      end
    end
  end

  // ----------------------------------------------------------
  // start-up delay and ready line
  // ----------------------------------------------------------
  // count the start-up delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_cnt <= '0;
      started <= 1'b0;
    end else if (!started) begin
      boot_cnt <= boot_cnt + 32'h1;
      started <= boot_done;
    end
  end

  // remember a sync entry until reported
  always_ff @(posedge clk_i) begin
    if (rst_i) sync_pend <= 1'b0;
    else if (sync_entered_i) sync_pend <= 1'b1;
    else if (pkt_end && tx_en && !from_fifo) sync_pend <= 1'b0;
  end

  // ready: first after delay, device requests
  // limitation: ready may dip for a cycle or two after a deselect,
  // while the select synchroniser still shows the old level
  wire dev_req = !tx_en || fifo_out_valid || sync_pend;
  always_comb begin
    ready_n = 1'b1;
    if (started && state == SPCG_IDLE && (selected || dev_req))
      ready_n = 1'b0;
    else if (state == SPCG_SHIFT)
      ready_n = 1'b0;
    // done and hold states keep ready inactive
  end

  // ----------------------------------------------------------
  // transmit buffer
  // ----------------------------------------------------------
  // 32 entries, overflow clears and halts
  // a push into a full buffer drops it all and blocks pushes until reset
  logic ovf;
  always_ff @(posedge clk_i) begin
    if (rst_i) ovf <= 1'b0;
    else if (data_valid_i && !fifo_in_ready) ovf <= 1'b1;
  end

  spcg_fifo #(.WIDTH(PKT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(data_valid_i && !fifo_in_ready),
    .in_valid_i(data_valid_i && !ovf),
    .in_ready_o(fifo_in_ready),
    .in_data_i(data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  // ----------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------
  // commands issue regardless of gate state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_o <= '0;
      cmd_valid_o <= 1'b0;
      ready_n_o <= 1'b1;
      miso_o <= 1'b0;
      tx_enable_o <= 1'b0;
      overflow_o <= 1'b0;
      data_ready_o <= 1'b0;
    end else begin
      cmd_valid_o <= pkt_end && (rx_cls != SPCG_C_NONE)
                     && (rx_cls != SPCG_C_SPECIAL);
      // command word stands until the next packet ends
      if (pkt_end) cmd_o <= '{cls: rx_cls, index: rx_index, data: rx_dat};
      ready_n_o <= ready_n;
      // next bit leaves in the cycle of the shift, a cycle ahead of the
      // host's next rise even at the slowest edge detection
      miso_o <= shift_out ? tx_sr[PKT_W-2] : tx_sr[PKT_W-1];
      tx_enable_o <= tx_en;
      overflow_o <= ovf;
      data_ready_o <= fifo_in_ready && !ovf;
    end
  end
endmodule
`default_nettype wire

// *** dv/spcg_gate_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// gate protocol checker
// ----------------------------------------
module spcg_gate_monitor
  import spcg_pkg::*;
#(
  parameter longint STARTUP_CYCLES = 200
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link pins
  input wire logic sck_i,
  input wire logic ready_n_o,
  // core side
  input wire spcg_pkg::spcg_cmd_t cmd_o,
  input wire logic cmd_valid_o,
  input wire logic data_valid_i,
  input wire logic data_ready_o,
  input wire logic tx_enable_o,
  input wire logic overflow_o
);
  longint up_cnt;
  logic [4:0] rise_cnt;
  logic pkt_end;

  // cycles since reset, link clock rises per packet
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_cnt <= 0;
      rise_cnt <= 5'h00;
      pkt_end <= 1'b0;
    end else begin
      if (up_cnt < STARTUP_CYCLES) up_cnt <= up_cnt + 1;
      if ($rose(sck_i)) rise_cnt <= rise_cnt + 5'h01;
      pkt_end <= $rose(sck_i) && rise_cnt == 5'h1f;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_reset_state;
    $fell(rst_i) |-> ready_n_o && !tx_enable_o && !overflow_o;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not cleared by reset");
  property p_startup;
    !ready_n_o |-> up_cnt >= STARTUP_CYCLES;
  endproperty
  a_startup: assert property (p_startup)
    else $error("ready before start-up wait");
  property p_release;
    pkt_end |-> ##[0:8] ready_n_o;
  endproperty
  a_release: assert property (p_release)
    else $error("ready not released after packet");
  property p_cmd_ready;
    cmd_valid_o |-> ready_n_o;
  endproperty
  a_cmd_ready: assert property (p_cmd_ready)
    else $error("command while ready active");
  property p_cmd_class;
    cmd_valid_o |-> cmd_o.cls != SPCG_C_NONE && cmd_o.cls != SPCG_C_SPECIAL;
  endproperty
  a_cmd_class: assert property (p_cmd_class)
    else $error("command for undecoded id");
  property p_ready_back;
    $rose(ready_n_o) ##1 !tx_enable_o [*4] |-> ##[0:6] !ready_n_o;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("closed gate left ready inactive");
  property p_ovf_cause;
    $rose(overflow_o) |-> $past(data_valid_i, 2) && !$past(data_ready_o, 2);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause)
    else $error("overflow without push to full buffer");
  property p_ovf_sticky;
    overflow_o |=> overflow_o && !data_ready_o;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow dropped or buffer reopened");

  c_cmd: cover property (cmd_valid_o);
  c_gate: cover property ($rose(tx_enable_o));
  c_ovf: cover property ($rose(overflow_o));
endmodule

bind spcg_gate spcg_gate_monitor #(
  .STARTUP_CYCLES(STARTUP_CYCLES)
) u_spcg_gate_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck_i), .ready_n_o(ready_n_o),
  .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .data_valid_i(data_valid_i),
  .data_ready_o(data_ready_o), .tx_enable_o(tx_enable_o),
  .overflow_o(overflow_o)
);
`default_nettype wire

// *** dv/spcg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host link master
// ----------------------------------------
module spcg_host_model (
  // clock
  input wire logic clk_i,
  // device side
  input wire logic ready_n_i,
  input wire logic miso_i,
  output logic sel_n_o,
  output logic sck_o,
  output logic mosi_o
);
  int timeouts = 0;

  // idle: deselected, clock still
  initial begin
    sel_n_o = 1'b1;
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end

  // bounded wait for ready at a level
  task automatic wait_ready(input logic lvl, input int n);
    int i;
    i = 0;
    while (ready_n_i !== lvl && i < n) begin
      @(posedge clk_i);
      i++;
    end
    if (i >= n) timeouts++;
  endtask

  // msb first, 160 ns link clock
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    sel_n_o <= 1'b0;
    wait_ready(1'b0, 400);
    for (int b = 31; b >= 0; b--) begin
      mosi_o <= tx[b];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      rx[b] = miso_i;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    mosi_o <= ~tx[0];
    wait_ready(1'b1, 20);
    sel_n_o <= 1'b1;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spcg_pkg::*;
  localparam longint STARTUP = 200;
  localparam logic [31:0] PART = {OID_PART, PART_DATA};
  localparam logic [31:0] STAT = {OID_STATUS, 24'h000001};
  localparam logic [7:0] IDS [13] = '{8'h01, 8'h02, 8'h03, 8'h0f, 8'h10,
    8'h15, 8'h16, 8'h1b, 8'h20, 8'h27, 8'h78, 8'h80, 8'h8f};
  localparam logic [3:0] IDX [13] = '{4'h1, 4'h2, 4'h3, 4'hf, 4'h0, 4'h5,
    4'h6, 4'hb, 4'h7, 4'h0, 4'h8, 4'h0, 4'hf};
  localparam spcg_class_t CLS [13] = '{SPCG_C_CFG, SPCG_C_CTRL, SPCG_C_ALLF,
    SPCG_C_RXLINE, SPCG_C_RXSET, SPCG_C_RXSET, SPCG_C_RXSET, SPCG_C_RXSET,
    SPCG_C_FRAME, SPCG_C_FRAME, SPCG_C_ADDREN, SPCG_C_SLOT, SPCG_C_SLOT};
  logic clk_i, rst_i, sel_n, sck, mosi, miso, ready_n, cmd_valid;
  logic data_valid, data_ready, sync_entered, tx_enable, overflow;
  spcg_cmd_t cmd, last_cmd;
  spcg_pkt_t data;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_cmd = 0;

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  spcg_gate #(.STARTUP_CYCLES(STARTUP)) u_spcg_gate (
    .clk_i(clk_i), .rst_i(rst_i), .sel_n_i(sel_n), .sck_i(sck),
    .mosi_i(mosi), .miso_o(miso), .ready_n_o(ready_n), .cmd_o(cmd),
    .cmd_valid_o(cmd_valid), .data_i(data), .data_valid_i(data_valid),
    .data_ready_o(data_ready), .sync_entered_i(sync_entered),
    .tx_enable_o(tx_enable), .overflow_o(overflow));
  spcg_host_model u_spcg_host_model (
    .clk_i(clk_i), .ready_n_i(ready_n), .miso_i(miso), .sel_n_o(sel_n),
    .sck_o(sck), .mosi_o(mosi));

  // keep the latest decoded command
  always @(posedge clk_i) begin
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd;
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_pkt(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one packet, then let command and gate settle
  task automatic pkt(input logic [31:0] tx, output logic [31:0] rx);
    u_spcg_host_model.xfer(tx, rx);
    if (u_spcg_host_model.timeouts != 0) begin
      n_mismatch++;
      tally_and_finish();
    end
    repeat (4) @(posedge clk_i);
  endtask

  // bounded wait for ready active with host idle
  task automatic wait_low(input int n, output int cyc);
    cyc = 0;
    while (ready_n !== 1'b0 && cyc < n) begin
      @(posedge clk_i);
      cyc++;
    end
    chk_bit("ready active", 1'b0, ready_n);
    if (cyc >= n) tally_and_finish();
  endtask

  task automatic push(input spcg_pkt_t p);
    data <= p;
    data_valid <= 1'b1;
    @(posedge clk_i);
    data_valid <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic t_startup();
    logic [31:0] rx;
    int cyc;
    wait_low(400, cyc);
    chk_bit("start-up wait", 1'b1, cyc >= STARTUP);
    pkt({ID_CHECKSUM, PART_DATA}, rx);
    chk_pkt("first reply", PART, rx);
    chk_bit("gate", 1'b1, tx_enable);
    $display("startup test done");
  endtask

  task automatic t_decode();
    logic [31:0] rx;
    logic [23:0] d;
    logic [23:0] sum;
    logic [3:0] ix;
    int n0;
    sum = PART_DATA;
    foreach (IDS[k]) begin
      d = {8'h3c, IDS[k], 8'h96};
      sum = sum ^ d;
      n0 = n_cmd;
      pkt({IDS[k], d}, rx);
      chk_pkt("reply", (k == 0) ? STAT : PART, rx);
      ix = IDX[k];
      chk_pkt("command", {CLS[k], ix, d}, last_cmd);
      chk_bit("one command", 1'b1, n_cmd == n0 + 1);
      chk_bit("gate", 1'b0, tx_enable);
    end
    n0 = n_cmd;
    pkt({ID_SPEC_LO, 24'hffffff}, rx);
    chk_bit("special", 1'b1, n_cmd == n0);
    pkt({ID_CHECKSUM, sum ^ 24'h000001}, rx);
    chk_bit("bad sum", 1'b0, tx_enable);
    pkt({ID_CHECKSUM, sum}, rx);
    chk_bit("good sum", 1'b1, tx_enable);
    $display("decode test done");
  endtask

  task automatic t_open();
    logic [31:0] rx;
    int cyc;
    pkt({ID_CHECKSUM, 24'h123456}, rx);
    chk_pkt("status", STAT, rx);
    chk_bit("gate kept", 1'b1, tx_enable);
    for (int j = 0; j < 3; j++) push({OID_MSG_LO + 8'(j), 24'hc0ffee ^ 24'(j)});
    for (int j = 0; j < 3; j++) begin
      wait_low(50, cyc);
      pkt(32'h00000000, rx);
      chk_pkt("buffered", {OID_MSG_LO + 8'(j), 24'hc0ffee ^ 24'(j)}, rx);
    end
    pkt(32'h00000000, rx);
    chk_pkt("drained", STAT, rx);
    $display("open gate test done");
  endtask

  task automatic t_sync();
    logic [31:0] rx;
    int cyc;
    sync_entered <= 1'b1;
    @(posedge clk_i);
    sync_entered <= 1'b0;
    wait_low(50, cyc);
    pkt(32'h00000000, rx);
    chk_pkt("sync status", {OID_STATUS, 24'h000003}, rx);
    $display("sync test done");
  endtask

  task automatic t_overflow();
    logic [31:0] rx;
    pkt({ID_CONFIG, 24'h000000}, rx);
    chk_bit("gate closed", 1'b0, tx_enable);
    for (int j = 0; j < FIFO_DEPTH; j++) push({OID_ADDR, 24'(j)});
    // registered flags show one cycle after the push lands
    @(posedge clk_i);
    chk_bit("full", 1'b0, data_ready);
    push({OID_ADDR, 24'h0000ff});
    @(posedge clk_i);
    chk_bit("overflow", 1'b1, overflow);
    chk_bit("blocked", 1'b0, data_ready);
    $display("overflow test done");
  endtask

  initial begin
    rst_i = 1'b1;
    data = '0;
    data_valid = 1'b0;
    sync_entered = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_startup();
    t_decode();
    t_open();
    t_sync();
    t_overflow();
    tally_and_finish();
  end
endmodule
`default_nettype wire
